// file: core/cpu_regs.sv
// programmer-visible register set with flag word, reset entry and axi4-lite access
// assumes a single 10 mhz clock; reset_n_i is already synchronised by the reset circuit
//
// Behaviour
// - 20-bit, one megabyte address space, rom top
// - fixed vectors start at fffdc hex
// - peripheral area 0 to 3ff, ram from 400
// - special page table ffe00 to fffdb
// - seven registers banked, one bank visible
// - 16-bit data regs, byte halves, pairs
// - address regs as data, pairable 32-bit
// - program counter is 20 bits
// - 20-bit interrupt vector table base
// - flag bit 7 selects stack pointer
// - stack select cleared on interrupt accept; code clears it only for hardware ones and software 0 to 31
// - bit 0 holds carry or shift-out
// - step flag raises interrupt, cleared on accept
// - bit 2 set on zero result
// - bit 3 set on negative result
// - bit 4 selects register bank
// - bit 5 set on overflow
// - bit 6 gates maskable, cleared on accept
// - accept only priority above level field
// - bits 8 to 11 and 15 reserved
// - after reset, fetch from reset vector
//
// Our own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "cpu_regs_defs.svh"

module cpu_regs
    import cpu_regs_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    // execution side
    input  wire irq_req_t    irq_req_i,
    input  wire logic        alu_update_i,
    input  wire alu_flags_t  alu_flags_i,
    input  wire logic        insn_done_i,
    input  wire logic [19:0] reset_vector_i,
    output logic             irq_ack_o,
    output logic             step_req_o,
    output logic             fetch_req_o,
    output logic [19:0]      fetch_addr_o,
    output logic [15:0]      flags_o,
    output logic [15:0]      active_sp_o
);

    state_t s;
    state_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    // 32-bit word masked by strobes, merged into a 20-bit or 16-bit target
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // classify a 20-bit address into its map region
    function automatic logic [2:0] region(input logic [19:0] a);
        logic [2:0] r;
        if (a <= `MAP_SFR_LAST) begin
            r = 3'h1;
        end else if (a >= `MAP_VEC_FIRST) begin
            r = 3'h4;
        end else if (a >= `MAP_SPG_FIRST && a <= `MAP_SPG_LAST) begin
            r = 3'h3;
        end else begin
            r = 3'h2;                                                  // ram and rom
        end
        return r;
    endfunction : region

    logic        bank_sel;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        irq_take;
    logic        sw_clear;

    assign bank_sel = s.flags[`FLG_BANK];

    ////////////////////////////////////////////////////////////////////////////
    // read decode, only the selected bank is visible
    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr_i)
            `OFF_DATA0:  rd_word = {16'h0000, s.bank[bank_sel].data0};
            `OFF_DATA1:  rd_word = {16'h0000, s.bank[bank_sel].data1};
            `OFF_DATA2:  rd_word = {16'h0000, s.bank[bank_sel].data2};
            `OFF_DATA3:  rd_word = {16'h0000, s.bank[bank_sel].data3};
            `OFF_ADDR0:  rd_word = {16'h0000, s.bank[bank_sel].addr0};
            `OFF_ADDR1:  rd_word = {16'h0000, s.bank[bank_sel].addr1};
            `OFF_FBASE:  rd_word = {16'h0000, s.bank[bank_sel].fbase};
            `OFF_PC:     rd_word = {12'h000, s.pc};
            `OFF_VTB:    rd_word = {12'h000, s.vtb};
            `OFF_USP:    rd_word = {16'h0000, s.user_stack_pointer};
            `OFF_ISP:    rd_word = {16'h0000, s.irq_stack_pointer};
            `OFF_SB:     rd_word = {16'h0000, s.sb};
            `OFF_FLAGS:  rd_word = {16'h0000, s.flags & `FLG_WMASK};
            `OFF_EVENT:  rd_word = {28'h0000000, s.events};
            `OFF_STATUS: rd_word = {28'h0000000, region(s.pc), s.run == RUN_EXEC};
            `OFF_RSTVEC: rd_word = {12'h000, `RESET_VEC};
            `OFF_MEMMAP: rd_word = {12'h000, `MAP_RAM_FIRST};
            default:     rd_hit  = 1'b0;
        endcase
    end

    // an interrupt is taken only above the current level; maskable ones need the enable
    always_comb begin
        irq_take = irq_req_i.valid && s.run == RUN_EXEC
                && irq_req_i.level > s.flags[`FLG_IPL_HI:`FLG_IPL_LO]
                && (s.flags[`FLG_IEN] || !irq_req_i.hw || irq_req_i.step);
        sw_clear = irq_req_i.valid && irq_req_i.sw && irq_req_i.sw_num <= `SW_INT_LAST;
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [31:0] m;
        logic [15:0] fl;
        m      = 32'h0000_0000;
        fl     = 16'h0000;
        next_s = s;
        next_s.irq_ack   = 1'b0;
        next_s.fetch_req = 1'b0;

        // run sequence: leave reset and fetch the reset vector once
        unique case (s.run)
            RUN_RESET: begin
                next_s.fetch_req  = 1'b1;
                next_s.fetch_addr = `RESET_VEC;
                next_s.run        = RUN_FETCH;
            end
            RUN_FETCH: begin
                next_s.pc  = reset_vector_i;
                next_s.run = RUN_EXEC;
            end
            RUN_EXEC: begin
                next_s.run = RUN_EXEC;
            end
            default: next_s.run = RUN_RESET;
        endcase

        // single-step request after each instruction while the step flag is set
        next_s.step_req = s.flags[`FLG_STEP] && insn_done_i && s.run == RUN_EXEC;

        // write channel capture, in either order
        if (s_axi_awvalid_i && !s.aw_ok && !s.bvalid) begin
            next_s.aw_ok   = 1'b1;
            next_s.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !s.w_ok && !s.bvalid) begin
            next_s.w_ok   = 1'b1;
            next_s.w_data = s_axi_wdata_i;
            next_s.w_strb = s_axi_wstrb_i;
        end

        fl = s.flags;
        // alu results update the arithmetic flags
        if (alu_update_i) begin
            fl[`FLG_CARRY] = alu_flags_i.carry;
            fl[`FLG_ZERO]  = alu_flags_i.zero;
            fl[`FLG_SIGN]  = alu_flags_i.sign;
            fl[`FLG_OVF]   = alu_flags_i.ovf;
        end

        // register write once both halves are held
        if (s.aw_ok && s.w_ok) begin
            next_s.aw_ok  = 1'b0;
            next_s.w_ok   = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp  = `AXI_OKAY;
            unique case (s.aw_addr)
                `OFF_DATA0: begin
                    m = merge({16'h0000, s.bank[bank_sel].data0}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].data0 = m[15:0];              // byte halves
                end
                `OFF_DATA1: begin
                    m = merge({16'h0000, s.bank[bank_sel].data1}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].data1 = m[15:0];
                end
                `OFF_DATA2: begin
                    m = merge({16'h0000, s.bank[bank_sel].data2}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].data2 = m[15:0];
                end
                `OFF_DATA3: begin
                    m = merge({16'h0000, s.bank[bank_sel].data3}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].data3 = m[15:0];
                end
                `OFF_ADDR0: begin
                    m = merge({16'h0000, s.bank[bank_sel].addr0}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].addr0 = m[15:0];
                end
                `OFF_ADDR1: begin
                    m = merge({16'h0000, s.bank[bank_sel].addr1}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].addr1 = m[15:0];
                end
                `OFF_FBASE: begin
                    m = merge({16'h0000, s.bank[bank_sel].fbase}, s.w_data, s.w_strb);
                    next_s.bank[bank_sel].fbase = m[15:0];
                end
                `OFF_PC: begin
                    m = merge({12'h000, s.pc}, s.w_data, s.w_strb);
                    next_s.pc = m[19:0];
                end
                `OFF_VTB: begin
                    m = merge({12'h000, s.vtb}, s.w_data, s.w_strb);
                    next_s.vtb = m[19:0];
                end
                `OFF_USP: begin
                    m = merge({16'h0000, s.user_stack_pointer}, s.w_data, s.w_strb);
                    next_s.user_stack_pointer = m[15:0];
                end
                `OFF_ISP: begin
                    m = merge({16'h0000, s.irq_stack_pointer}, s.w_data, s.w_strb);
                    next_s.irq_stack_pointer = m[15:0];
                end
                `OFF_SB: begin
                    m = merge({16'h0000, s.sb}, s.w_data, s.w_strb);
                    next_s.sb = m[15:0];
                end
                `OFF_FLAGS: begin
                    m = merge({16'h0000, fl}, s.w_data, s.w_strb);
                    fl = m[15:0] & `FLG_WMASK;
                end
                `OFF_EVENT: begin
                    // write one to clear; a new event below still wins
                    next_s.events = s.events & ~s.w_data[3:0];
                end
                `OFF_STATUS, `OFF_RSTVEC, `OFF_MEMMAP: begin
                    next_s.bresp = `AXI_OKAY;                          // read only, ignored
                end
                default: next_s.bresp = `AXI_SLVERR;
            endcase
        end

        // accepting an interrupt clears enable; step only for a step request, stack select for a hardware one (software 0 to 31 clear it below)
        if (irq_take) begin
            next_s.irq_ack = 1'b1;
            fl[`FLG_IEN]   = 1'b0;
            if (irq_req_i.step) begin
                fl[`FLG_STEP] = 1'b0;
            end
            if (irq_req_i.hw) begin
                fl[`FLG_STACK] = 1'b0;
            end
        end
        if (sw_clear && s.run == RUN_EXEC) begin
            fl[`FLG_STACK] = 1'b0;
        end
        next_s.flags = fl;

        // sticky events, set beats clear
        if (irq_take && irq_req_i.hw) begin
            next_s.events[`EV_HW_IRQ] = 1'b1;
        end
        if (sw_clear && s.run == RUN_EXEC) begin
            next_s.events[`EV_SW_INT] = 1'b1;
        end
        if (irq_take && irq_req_i.step) begin
            next_s.events[`EV_STEP_ACK] = 1'b1;
        end
        if (alu_update_i) begin
            next_s.events[`EV_ALU] = 1'b1;
        end

        if (s.bvalid && s_axi_bready_i) begin
            next_s.bvalid = 1'b0;
        end

        // read: accept when no answer is pending
        if (s.rvalid && s_axi_rready_i) begin
            next_s.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = rd_word;
            next_s.rresp  = rd_hit ? `AXI_OKAY : `AXI_SLVERR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; the flag word clears on every reset so bank 0, isp,
    // level 0 and masked interrupts are in force. the 20-cycle low time is the
    // reset circuit's duty, a single low edge already suffices here.
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            s       <= '0;
            s.flags <= `FLG_RESET;
            s.run   <= RUN_RESET;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs from state flip-flops only, the ready lines and active_sp_o through gates or a mux
    assign s_axi_awready_o = !s.aw_ok && !s.bvalid;
    assign s_axi_wready_o  = !s.w_ok && !s.bvalid;
    assign s_axi_bvalid_o  = s.bvalid;
    assign s_axi_bresp_o   = s.bresp;
    assign s_axi_arready_o = !s.rvalid;
    assign s_axi_rvalid_o  = s.rvalid;
    assign s_axi_rdata_o   = s.rdata;
    assign s_axi_rresp_o   = s.rresp;
    assign irq_ack_o       = s.irq_ack;
    assign step_req_o      = s.step_req;
    assign fetch_req_o     = s.fetch_req;
    assign fetch_addr_o    = s.fetch_addr;
    assign flags_o         = s.flags;
    // stack pointer picked by flag bit 7
    assign active_sp_o     = s.flags[`FLG_STACK] ? s.user_stack_pointer : s.irq_stack_pointer;

endmodule : cpu_regs

// file: core/cpu_regs_defs.svh
// register offsets, flag field positions, reset values and memory map constants
// assumes inclusion from the register file package and module only
`ifndef CPU_REGS_DEFS_SVH
`define CPU_REGS_DEFS_SVH

// axi byte offsets, one aligned word each
`define OFF_DATA0      8'h00
`define OFF_DATA1      8'h04
`define OFF_DATA2      8'h08
`define OFF_DATA3      8'h0c
`define OFF_ADDR0      8'h10
`define OFF_ADDR1      8'h14
`define OFF_FBASE      8'h18
`define OFF_PC         8'h1c
`define OFF_VTB        8'h20
`define OFF_USP        8'h24
`define OFF_ISP        8'h28
`define OFF_SB         8'h2c
`define OFF_FLAGS      8'h30
`define OFF_EVENT      8'h34
`define OFF_STATUS     8'h38
`define OFF_RSTVEC     8'h3c
`define OFF_MEMMAP     8'h40

// flag bit positions
`define FLG_CARRY      0
`define FLG_STEP       1
`define FLG_ZERO       2
`define FLG_SIGN       3
`define FLG_BANK       4
`define FLG_OVF        5
`define FLG_IEN        6
`define FLG_STACK      7
`define FLG_IPL_LO     12
`define FLG_IPL_HI     14
`define FLG_WMASK      16'h70ff
`define FLG_RESET      16'h0000

// event register bits
`define EV_HW_IRQ      0
`define EV_SW_INT      1
`define EV_STEP_ACK    2
`define EV_ALU         3

// memory map, 20-bit byte addresses
`define MAP_SFR_LAST   20'h003ff
`define MAP_RAM_FIRST  20'h00400
`define MAP_SPG_FIRST  20'hffe00
`define MAP_SPG_LAST   20'hfffdb
`define MAP_VEC_FIRST  20'hfffdc
`define MAP_TOP        20'hfffff
`define RESET_VEC      20'hffffc

`define SW_INT_LAST    6'd31
`define AXI_OKAY       2'b00
`define AXI_SLVERR     2'b10

`endif

// file: core/cpu_regs_pkg.sv
// types shared by the processor register file
// assumes the defines header is on the include path
package cpu_regs_pkg;
    typedef enum logic [1:0] {
        RUN_RESET = 2'b00,
        RUN_FETCH = 2'b01,
        RUN_EXEC  = 2'b10
    } run_state_t;

    typedef struct packed {
        logic [15:0] data0;
        logic [15:0] data1;
        logic [15:0] data2;
        logic [15:0] data3;
        logic [15:0] addr0;
        logic [15:0] addr1;
        logic [15:0] fbase;
    } bank_t;

    typedef struct packed {
        logic        carry;
        logic        zero;
        logic        sign;
        logic        ovf;
    } alu_flags_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  level;
        logic        hw;
        logic        sw;
        logic [5:0]  sw_num;
        logic        step;
    } irq_req_t;

    typedef struct packed {
        bank_t [1:0] bank;
        logic [19:0] pc;
        logic [19:0] vtb;
        logic [15:0] user_stack_pointer;
        logic [15:0] irq_stack_pointer;
        logic [15:0] sb;
        logic [15:0] flags;
        logic [3:0]  events;
        run_state_t  run;
        logic        aw_ok;
        logic        w_ok;
        logic [7:0]  aw_addr;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        irq_ack;
        logic        step_req;
        logic [19:0] fetch_addr;
        logic        fetch_req;
    } state_t;
endpackage : cpu_regs_pkg

// file: testbench/cpu_regs_checker.sv
// checker: flag word, reset entry and interrupt side effects at the top ports
// assumes one clock domain and a synchronous active low reset
`timescale 1ns/100ps
module cpu_regs_checker
    import cpu_regs_pkg::*;
(
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic        s_axi_bvalid_o,
    input wire irq_req_t    irq_req_i,
    input wire logic        alu_update_i,
    input wire alu_flags_t  alu_flags_i,
    input wire logic        insn_done_i,
    input wire logic        irq_ack_o,
    input wire logic        step_req_o,
    input wire logic        fetch_req_o,
    input wire logic [19:0] fetch_addr_o,
    input wire logic [15:0] flags_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////
    // reset entry is two steps: release, then a single vector fetch
    sequence s_release;
        $rose(reset_n_i);
    endsequence
    sequence s_fetch;
        fetch_req_o && fetch_addr_o == 20'hffffc;
    endsequence
    a_reset_entry_fetch: assert property (s_release |=> s_fetch ##1 !fetch_req_o)
        else $error("reset vector fetch missing or not a single pulse");
    // checked while reset is low, so this one cannot use the default disable
    a_reset_clears_flags: assert property (disable iff (1'b0)
        !reset_n_i |=> flags_o == 16'h0)
        else $error("flag word not cleared by reset");
    a_reserved_bits_zero: assert property (flags_o[11:8] == 4'h0 && !flags_o[15])
        else $error("reserved flag bits not zero");

    ////////////////////////////////////////////////////////////////
    // interrupt acceptance and its side effects on the flag word
    a_ack_above_level: assert property (irq_ack_o |-> $past(irq_req_i.valid)
        && $past(irq_req_i.level) > $past(flags_o[14:12]))
        else $error("interrupt accepted at or below the priority level");
    a_ack_clears_enable: assert property (irq_ack_o |-> !flags_o[6])
        else $error("enable flag still set after acceptance");
    a_ack_clears_stack: assert property (irq_ack_o && ($past(irq_req_i.hw)
        || $past(irq_req_i.sw) && $past(irq_req_i.sw_num) <= 6'd31) |-> !flags_o[7])
        else $error("stack select flag not cleared");
    a_step_ack_clear: assert property (irq_ack_o && $past(irq_req_i.step) |-> !flags_o[1])
        else $error("step flag not cleared on acceptance");
    a_step_request: assert property (insn_done_i && flags_o[1] && $past(reset_n_i, 2)
        |=> step_req_o)
        else $error("no step request after instruction");
    a_step_cause: assert property (step_req_o |-> $past(insn_done_i) && $past(flags_o[1]))
        else $error("step request without cause");
    // a bus write to the flag word's low byte landing on the same edge wins over the arithmetic update
    a_alu_flag_load: assert property (alu_update_i |=>
        $rose(s_axi_bvalid_o)
        || {flags_o[0], flags_o[2], flags_o[3], flags_o[5]} == $past(alu_flags_i))
        else $error("arithmetic flags not loaded");
endmodule : cpu_regs_checker

bind cpu_regs cpu_regs_checker u_cpu_regs_checker (
    .clock_i, .reset_n_i, .s_axi_bvalid_o, .irq_req_i, .alu_update_i, .alu_flags_i,
    .insn_done_i, .irq_ack_o, .step_req_o, .fetch_req_o, .fetch_addr_o, .flags_o
);

// file: testbench/reset_source.sv
// reset source model: drives the active low reset pin of the register file
// assumes start_i is a one-cycle request from the bench, on clock_i
`timescale 1ns/100ps
module reset_source #(
    parameter int HOLD = 20
) (
    input  wire logic clock_i,
    input  wire logic start_i,
    output logic      reset_n_o
);
    int count = HOLD;

    // pin held low for HOLD edges from power-up and after each request
    always @(posedge clock_i) begin
        if (start_i) count <= HOLD;
        else if (count > 0) count <= count - 1;
    end
    assign reset_n_o = (count == 0);
endmodule : reset_source

// file: testbench/tb_top.sv
// bench top: register file, reset source, bus tasks and result scoreboard
// assumes design, package and checker files are compiled ahead of this one
`timescale 1ns/100ps
module tb_top;
    import cpu_regs_pkg::*;
    logic        clock_i   = 1'b0;
    logic        rst_req   = 1'b0;
    logic        reset_n;
    logic [7:0]  awaddr    = 8'h00;
    logic [7:0]  araddr    = 8'h00;
    logic        awvalid   = 1'b0;
    logic        wvalid    = 1'b0;
    logic        arvalid   = 1'b0;
    logic        bready    = 1'b1;
    logic        rready    = 1'b1;
    logic [31:0] wdata     = 32'h0;
    irq_req_t    irq_req   = '0;
    logic        alu_upd   = 1'b0;
    alu_flags_t  alu_fl    = '0;
    logic        insn_done = 1'b0;
    logic [19:0] rst_vec   = 20'h7f61c;
    logic [31:0] lfsr      = 32'h647df61c;
    logic        awready, wready, bvalid, arready, rvalid, irq_ack, step_req, fetch_req;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata, v0;
    logic [19:0] fetch_addr;
    logic [15:0] flags, asp;
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    logic [31:0] vals[12];
    int          err_count = 0;
    int          check_count = 0;
    int          i;
    logic [19:0] pcs[6]    = '{20'h003ff, 20'h00400, 20'hffdff, 20'hffe00, 20'hfffdb, 20'hfffdc};
    logic [2:0]  region[6] = '{3'd1, 3'd2, 3'd2, 3'd3, 3'd3, 3'd4};

    initial forever #50 clock_i = ~clock_i;

    reset_source #(.HOLD(20)) u_reset_source (.clock_i(clock_i), .start_i(rst_req),
        .reset_n_o(reset_n));

    cpu_regs u_cpu_regs (
        .clock_i(clock_i), .reset_n_i(reset_n),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .irq_req_i(irq_req), .alu_update_i(alu_upd), .alu_flags_i(alu_fl),
        .insn_done_i(insn_done), .reset_vector_i(rst_vec), .irq_ack_o(irq_ack),
        .step_req_o(step_req), .fetch_req_o(fetch_req), .fetch_addr_o(fetch_addr),
        .flags_o(flags), .active_sp_o(asp)
    );

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt

    task automatic end_of_test;
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic hang;
        err_count++;
        end_of_test();
    endtask : hang

    task automatic chk_rd(input logic [33:0] e, input logic [33:0] g);
        check_count++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED read resp/data expected %h seen %h", e, g);
        end
    endtask : chk_rd

    task automatic chk_wr(input logic [1:0] e, input logic [1:0] g);
        check_count++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED write resp expected %h seen %h", e, g);
        end
    endtask : chk_wr

    task automatic chk_sig(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk_sig

    // each channel is released at the edge that takes it; ready lines stay high
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        int n;
        bq.push_back(r);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 40) hang();
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rq.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clock_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 40) hang();
    endtask : rd

    // one-cycle request; the answer is due one edge after the taking edge
    task automatic irq(input logic [2:0] lv, input logic hw, input logic sw,
                       input logic [5:0] num, input logic st, input logic ack);
        irq_req <= '{1'b1, lv, hw, sw, num, st};
        @(posedge clock_i);
        irq_req.valid <= 1'b0;
        @(posedge clock_i);
        chk_sig("irq_ack_o", {15'h0, ack}, {15'h0, irq_ack});
    endtask : irq

    task automatic done(input logic e);
        insn_done <= 1'b1;
        @(posedge clock_i);
        insn_done <= 1'b0;
        @(posedge clock_i);
        chk_sig("step_req_o", {15'h0, e}, {15'h0, step_req});
    endtask : done

    // scoreboard: oldest expectation against each answer as it appears
    always @(posedge clock_i) begin
        if (rvalid && rready) chk_rd(rq.pop_front(), {rresp, rdata});
        if (bvalid && bready) chk_wr(bq.pop_front(), bresp);
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (24) @(posedge clock_i);
        rd(8'h1c, {14'h0, rst_vec});
        rd(8'h30, 34'h0);
        rd(8'h3c, {14'h0, 20'hffffc});
        rd(8'h40, {14'h0, 20'h00400});
        rd(8'h80, {2'b10, 32'h0});
        wr(8'h44, 32'h1, 2'b10);
        wr(8'h3c, 32'h0, 2'b00);
        rd(8'h3c, {14'h0, 20'hffffc});
        // map regions at both edges of each boundary
        for (i = 0; i < 6; i++) begin
            wr(8'h1c, {12'h0, pcs[i]}, 2'b00);
            rd(8'h38, {30'h0, region[i], 1'b1});
        end
        for (i = 0; i < 12; i++) begin
            lfsr = nxt(lfsr);
            vals[i] = lfsr & ((i == 7 || i == 8) ? 32'hfffff : 32'hffff);
            wr(8'(4 * i), lfsr, 2'b00);
            rd(8'(4 * i), {2'b00, vals[i]});
        end
        v0 = ~vals[0];
        wr(8'h30, 32'h10, 2'b00);
        wr(8'h00, v0, 2'b00);
        rd(8'h00, {18'h0, v0[15:0]});
        wr(8'h30, 32'h0, 2'b00);
        rd(8'h00, {2'b00, vals[0]});
        wr(8'h30, 32'hffffffff, 2'b00);
        rd(8'h30, {18'h0, 16'h70ff});
        wr(8'h30, 32'h80, 2'b00);
        chk_sig("active_sp_o", vals[9][15:0], asp);
        wr(8'h30, 32'h0, 2'b00);
        chk_sig("active_sp_o", vals[10][15:0], asp);
        for (i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            alu_fl  <= lfsr[3:0];
            alu_upd <= 1'b1;
            @(posedge clock_i);
            alu_upd <= 1'b0;
            @(posedge clock_i);
            chk_sig("flags_o", {10'h0, lfsr[0], 1'b0, lfsr[1], lfsr[2], 1'b0, lfsr[3]},
                flags);
        end
        wr(8'h30, 32'h30c0, 2'b00);
        irq(3'd3, 1'b1, 1'b0, 6'd0, 1'b0, 1'b0);
        irq(3'd4, 1'b1, 1'b0, 6'd0, 1'b0, 1'b1);
        chk_sig("flags_o", 16'h3000, flags);
        irq(3'd7, 1'b1, 1'b0, 6'd0, 1'b0, 1'b0);
        wr(8'h30, 32'h3080, 2'b00);
        irq(3'd4, 1'b0, 1'b1, 6'd31, 1'b0, 1'b1);
        chk_sig("flags_o", 16'h3000, flags);
        wr(8'h30, 32'h3080, 2'b00);
        irq(3'd4, 1'b0, 1'b1, 6'd32, 1'b0, 1'b1);
        chk_sig("flags_o", 16'h3080, flags);
        wr(8'h30, 32'h0002, 2'b00);
        done(1'b1);
        irq(3'd1, 1'b0, 1'b0, 6'd0, 1'b1, 1'b1);
        chk_sig("flags_o", 16'h0000, flags);
        done(1'b0);
        rd(8'h34, 34'hf);
        // second reset in mid-run, with a new entry address
        wr(8'h30, 32'h70ff, 2'b00);
        rst_vec <= lfsr[31:12];
        rst_req <= 1'b1;
        @(posedge clock_i);
        rst_req <= 1'b0;
        repeat (24) @(posedge clock_i);
        chk_sig("flags_o", 16'h0000, flags);
        rd(8'h1c, {14'h0, lfsr[31:12]});
        end_of_test();
    end
endmodule : tb_top
